/* File: rtl/pch_pkg.sv */
// Package: offsets, layouts and constants of the configuration header block
package pch_pkg;

  localparam logic [7:0]  OFS_CLASS_REV   = 8'h08;
  localparam logic [7:0]  OFS_MISC        = 8'h0c;
  localparam logic [7:0]  OFS_IO_BASE     = 8'h10;
  localparam logic [7:0]  OFS_MEM_BASE    = 8'h14;
  localparam logic [7:0]  OFS_SUBSYS      = 8'h2c;
  localparam logic [7:0]  OFS_ROM_BASE    = 8'h30;
  localparam logic [7:0]  OFS_CAP_PTR     = 8'h34;
  localparam logic [7:0]  OFS_COMMAND     = 8'h04;

  localparam logic [23:0] CLASS_CODE      = 24'h020000;
  localparam logic [7:0]  SELF_TEST_VAL   = 8'h00;
  localparam logic [7:0]  HDR_SINGLE      = 8'h00;
  localparam logic [7:0]  HDR_MULTI       = 8'h80;
  localparam logic [7:0]  CACHE_LINE_VAL  = 8'h00;
  localparam logic [7:0]  CAP_PTR_VAL     = 8'h50;
  localparam int          BASE_LSB        = 7;
  localparam int          ROM_LSB         = 18;
  localparam logic [7:0]  LAT_RESET       = 8'h00;
  localparam logic [2:0]  CMD_RESET       = 3'h7;
  localparam int          CMD_MEM_BIT     = 1;

  // Config access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  ofs;
    logic [31:0] wdata;
    logic [3:0]  be;
  } pch_cfg_req_s;

  // Address phase from the target decoder
  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        is_mem;
    logic [31:0] addr;
  } pch_addr_s;

  typedef enum logic [1:0] {
    MST_IDLE = 2'b00,
    MST_RUN  = 2'b01,
    MST_END  = 2'b10
  } pch_mst_e;

endpackage : pch_pkg

/* File: rtl/pch_base_cmp.sv */
`timescale 1ns/1ps
// Module: compares an address against a base field
module pch_base_cmp
  import pch_pkg::*;
#(
  parameter int LSB = 7
) (
  // Compare inputs
  input  wire logic [31:0] addr,
  input  wire logic [31:0] base,
  input  wire logic        enable,
  // Result
  output logic             hit
);

  initial begin
    if (LSB < 1 || LSB > 31) $error("pch_base_cmp: bad LSB");
  end

  assign hit = enable && (addr[31:LSB] == base[31:LSB]);

endmodule : pch_base_cmp

/* File: rtl/pch_lat_timer.sv */
`timescale 1ns/1ps
// Module: master latency down-counter and tenure end decision
module pch_lat_timer
  import pch_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Bus master events
  input  wire logic         frame_start,
  input  wire logic         frame_end,
  input  wire logic         gnt,
  input  wire logic [W-1:0] lat_value,
  // Result
  output logic              must_end,
  output logic              expired
);

  typedef struct packed {
    pch_mst_e       st;
    logic [W-1:0]   cnt;
  } pch_lat_state_s;

  pch_lat_state_s s_q, s_d;

  initial begin
    if (W < 1) $error("pch_lat_timer: bad width");
  end

  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      MST_IDLE: begin
        if (frame_start) begin
          s_d.cnt = lat_value;
          s_d.st  = MST_RUN;
        end
      end
      MST_RUN: begin
        if (frame_end) begin
          s_d.st = MST_IDLE;
        end else begin
          if (s_q.cnt != '0) s_d.cnt = s_q.cnt - 1'b1;
          if (s_q.cnt == '0 && !gnt) s_d.st = MST_END;
        end
      end
      MST_END: begin
        if (frame_end) s_d.st = MST_IDLE;
      end
      default: s_d.st = MST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.st  <= MST_IDLE;
      s_q.cnt <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired  = (s_q.st != MST_IDLE) && (s_q.cnt == '0);
  // Ends when counter expired and grant removed, whichever came last
  assign must_end = (s_q.st == MST_END) ||
                    ((s_q.st == MST_RUN) && (s_q.cnt == '0) && !gnt);

endmodule : pch_lat_timer

/* File: rtl/pch_cfg_regs.sv */
`timescale 1ns/1ps
// Module: configuration header registers 04h..34h with decode
// Summary of operation
// - Class code bits 31:8 read 020000h, writes ignored.
// - Revision major in 7:4, minor in 3:0, read only.
// - Self-test byte reads zero.
// - Header type reads 00h, or 80h with multi-function strap high.
// - Latency value loads down-counter at own FRAME start, decrements per clock.
// - Counter expired with grant held: end as soon as grant removed.
// - Grant removed with counter nonzero: continue until counter expires.
// - Cache line size reads zero, ignores writes.
// - I/O base 31:7 compared with AD 31:7 on I/O commands; claim on match when command bit 0 set.
// - I/O base bits 6:1 read zero, bit 0 reads one.
// - Memory base 31:7 compared on memory commands; claim on match.
// - Memory base bits 6:1 and bit 0 read zero.
// - Subsystem ID 31:16 from EEPROM word 1.
// - Subsystem vendor ID 15:0 from EEPROM word 0.
// - ROM base 31:18 writable, 17:10 forced zero, 9:1 read zero.
// - ROM decode only when ROM enable and memory-space enable set.
// - Capability pointer reads 50h, upper bits zero.
// - Capability pointer low two bits always zero.
// - Command bit 1 gates all memory responses; resets to one.
module pch_cfg_regs
  import pch_pkg::*;
#(
  parameter logic [3:0] REV_MAJOR = 4'h1, // Arbitrary value
  parameter logic [3:0] REV_MINOR = 4'h1, // Arbitrary value
  parameter int         LAT_W     = 8
) (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // Configuration access
  input  wire logic        CFG_RD,
  input  wire logic        CFG_WR,
  input  wire logic [7:0]  CFG_OFS,
  input  wire logic [31:0] CFG_WDATA,
  input  wire logic [3:0]  CFG_BE,
  output logic [31:0]      CFG_RDATA,
  output logic             CFG_RVALID,
  // Straps and EEPROM words
  input  wire logic        MULTI_FUNC_STRAP,
  input  wire logic        EE_LOAD,
  input  wire logic [15:0] EE_WORD0,
  input  wire logic [15:0] EE_WORD1,
  // Address phase
  input  wire logic        ADDR_VALID,
  input  wire logic        ADDR_IS_IO,
  input  wire logic        ADDR_IS_MEM,
  input  wire logic [31:0] AD,
  output logic             IO_HIT,
  output logic             MEM_HIT,
  output logic             ROM_HIT,
  // Bus master tenure
  input  wire logic        MST_FRAME_START,
  input  wire logic        MST_FRAME_END,
  input  wire logic        GNT_ACTIVE,
  output logic             MST_MUST_END,
  output logic             LAT_EXPIRED
);

  initial begin
    if (LAT_W != 8) $error("pch_cfg_regs: latency field is 8 bits");
  end

  typedef struct packed {
    logic [2:0]  cmd;
    logic [7:0]  lat;
    logic [24:0] io_base;
    logic [24:0] mem_base;
    logic [13:0] rom_base;
    logic        rom_en;
    logic [31:0] subsys;
    logic        multi;
    logic [31:0] rdata;
    logic        rvalid;
  } pch_regs_s;

  pch_regs_s r_q, r_d;

  pch_cfg_req_s req;
  pch_addr_s    aph;
  logic [31:0]  io_word, mem_word, rom_word, rd_mux;
  logic         mem_en;

  assign req = '{rd: CFG_RD, wr: CFG_WR, ofs: CFG_OFS, wdata: CFG_WDATA, be: CFG_BE};
  assign aph = '{valid: ADDR_VALID, is_io: ADDR_IS_IO, is_mem: ADDR_IS_MEM, addr: AD};

  assign io_word  = {r_q.io_base, 6'h00, 1'b1};
  assign mem_word = {r_q.mem_base, 6'h00, 1'b0};
  assign rom_word = {r_q.rom_base, 8'h00, 9'h000, r_q.rom_en};
  assign mem_en   = r_q.cmd[CMD_MEM_BIT];

  always_comb begin
    unique case (req.ofs)
      OFS_COMMAND:   rd_mux = {29'h0, r_q.cmd};
      OFS_CLASS_REV: rd_mux = {CLASS_CODE, REV_MAJOR, REV_MINOR};
      OFS_MISC:      rd_mux = {SELF_TEST_VAL, (r_q.multi ? HDR_MULTI : HDR_SINGLE),
                               r_q.lat, CACHE_LINE_VAL};
      OFS_IO_BASE:   rd_mux = io_word;
      OFS_MEM_BASE:  rd_mux = mem_word;
      OFS_SUBSYS:    rd_mux = r_q.subsys;
      OFS_ROM_BASE:  rd_mux = rom_word;
      OFS_CAP_PTR:   rd_mux = {24'h000000, CAP_PTR_VAL[7:2], 2'b00};
      default:       rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    r_d        = r_q;
    r_d.multi  = MULTI_FUNC_STRAP;
    r_d.rvalid = req.rd;
    if (req.rd) r_d.rdata = rd_mux;
    if (EE_LOAD) r_d.subsys = {EE_WORD1, EE_WORD0};
    if (req.wr) begin
      unique case (req.ofs)
        OFS_COMMAND: begin
          if (req.be[0]) r_d.cmd = req.wdata[2:0];
        end
        OFS_MISC: begin
          if (req.be[1]) r_d.lat = req.wdata[15:8];
        end
        OFS_IO_BASE: begin
          if (req.be[0]) r_d.io_base[0]     = req.wdata[7];
          if (req.be[1]) r_d.io_base[8:1]   = req.wdata[15:8];
          if (req.be[2]) r_d.io_base[16:9]  = req.wdata[23:16];
          if (req.be[3]) r_d.io_base[24:17] = req.wdata[31:24];
        end
        OFS_MEM_BASE: begin
          if (req.be[0]) r_d.mem_base[0]     = req.wdata[7];
          if (req.be[1]) r_d.mem_base[8:1]   = req.wdata[15:8];
          if (req.be[2]) r_d.mem_base[16:9]  = req.wdata[23:16];
          if (req.be[3]) r_d.mem_base[24:17] = req.wdata[31:24];
        end
        OFS_ROM_BASE: begin
          if (req.be[0]) r_d.rom_en          = req.wdata[0];
          if (req.be[2]) r_d.rom_base[5:0]   = req.wdata[23:18];
          if (req.be[3]) r_d.rom_base[13:6]  = req.wdata[31:24];
        end
        default: r_d.cmd = r_q.cmd;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      r_q.cmd      <= CMD_RESET;
      r_q.lat      <= LAT_RESET;
      r_q.io_base  <= '0;
      r_q.mem_base <= '0;
      r_q.rom_base <= '0;
      r_q.rom_en   <= 1'b0;
      r_q.subsys   <= '0;
      r_q.multi    <= 1'b0;
      r_q.rdata    <= '0;
      r_q.rvalid   <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  assign CFG_RDATA  = r_q.rdata;
  assign CFG_RVALID = r_q.rvalid;

  logic io_cmp, mem_cmp, rom_cmp;

  pch_base_cmp #(.LSB(BASE_LSB)) u_io_cmp (
    .addr   (aph.addr),
    .base   (io_word),
    .enable (aph.valid && aph.is_io && r_q.cmd[0]),
    .hit    (io_cmp)
  );

  pch_base_cmp #(.LSB(BASE_LSB)) u_mem_cmp (
    .addr   (aph.addr),
    .base   (mem_word),
    .enable (aph.valid && aph.is_mem && mem_en),
    .hit    (mem_cmp)
  );

  pch_base_cmp #(.LSB(ROM_LSB)) u_rom_cmp (
    .addr   (aph.addr),
    .base   (rom_word),
    .enable (aph.valid && aph.is_mem && mem_en && r_q.rom_en),
    .hit    (rom_cmp)
  );

  assign IO_HIT  = io_cmp;
  assign MEM_HIT = mem_cmp;
  assign ROM_HIT = rom_cmp;

  pch_lat_timer #(.W(LAT_W)) u_lat (
    .clk         (CLOCK),
    .rst         (SYS_RST),
    .frame_start (MST_FRAME_START),
    .frame_end   (MST_FRAME_END),
    .gnt         (GNT_ACTIVE),
    .lat_value   (r_q.lat),
    .must_end    (MST_MUST_END),
    .expired     (LAT_EXPIRED)
  );

endmodule : pch_cfg_regs

/* File: sim/pch_host_model.sv */
`timescale 1ns/1ps
// Host arbiter model: holds grant a commanded number of cycles
module pch_host_model
  import pch_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Tenure control
  input  wire logic       frame_start,
  input  wire logic [7:0] hold,
  output logic            gnt
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk) begin
    if (rst) cnt_q <= 8'h00;
    else if (frame_start) cnt_q <= hold;
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end
  assign gnt = frame_start || (cnt_q != 8'h00);
endmodule : pch_host_model

/* File: sim/pch_cfg_regs_properties.sv */
`timescale 1ns/1ps
// Checker: read values and decode properties of the header block
module pch_cfg_regs_properties
  import pch_pkg::*;
(
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  // Observed ports
  input wire logic        CFG_RD,
  input wire logic [7:0]  CFG_OFS,
  input wire logic        CFG_WR,
  input wire logic [31:0] CFG_WDATA,
  input wire logic [3:0]  CFG_BE,
  input wire logic [31:0] CFG_RDATA,
  input wire logic        CFG_RVALID,
  input wire logic        MULTI_FUNC_STRAP,
  input wire logic        ADDR_VALID,
  input wire logic        ADDR_IS_MEM,
  input wire logic        MEM_HIT,
  input wire logic        ROM_HIT,
  input wire logic        GNT_ACTIVE,
  input wire logic        MST_MUST_END
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // Shadow of the memory-space and ROM decode enables, seen from the write port
  logic mem_en_q, rom_en_q;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      mem_en_q <= CMD_RESET[CMD_MEM_BIT];
      rom_en_q <= 1'b0;
    end else if (CFG_WR && CFG_BE[0]) begin
      if (CFG_OFS == OFS_COMMAND) mem_en_q <= CFG_WDATA[CMD_MEM_BIT];
      if (CFG_OFS == OFS_ROM_BASE) rom_en_q <= CFG_WDATA[0];
    end
  end
  sequence s_rd(o); CFG_RD && CFG_OFS == o; endsequence
  property p_rvalid; CFG_RD |=> CFG_RVALID; endproperty
  property p_rvalid_low; !CFG_RD |=> !CFG_RVALID; endproperty
  property p_class; s_rd(OFS_CLASS_REV) |=> CFG_RDATA[31:8] == CLASS_CODE; endproperty
  property p_misc;
    s_rd(OFS_MISC) |=> CFG_RDATA[31:24] == SELF_TEST_VAL && CFG_RDATA[7:0] == CACHE_LINE_VAL;
  endproperty
  property p_hdr;
    CFG_RD && CFG_OFS == OFS_MISC && $past(MULTI_FUNC_STRAP) && !$past(SYS_RST)
      |=> CFG_RDATA[23:16] == HDR_MULTI;
  endproperty
  property p_hdr_single;
    CFG_RD && CFG_OFS == OFS_MISC && !$past(MULTI_FUNC_STRAP)
      |=> CFG_RDATA[23:16] == HDR_SINGLE;
  endproperty
  property p_io; s_rd(OFS_IO_BASE) |=> CFG_RDATA[6:0] == 7'h01; endproperty
  property p_mem; s_rd(OFS_MEM_BASE) |=> CFG_RDATA[6:0] == 7'h00; endproperty
  property p_rom; s_rd(OFS_ROM_BASE) |=> CFG_RDATA[17:1] == 17'h00000; endproperty
  property p_cap; s_rd(OFS_CAP_PTR) |=> CFG_RDATA == 32'h00000050; endproperty
  property p_romhit; ROM_HIT |-> ADDR_VALID && ADDR_IS_MEM && mem_en_q && rom_en_q; endproperty
  property p_memhit; MEM_HIT |-> ADDR_VALID && ADDR_IS_MEM && mem_en_q; endproperty
  property p_end; MST_MUST_END |-> !GNT_ACTIVE; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  a_rvalid_low: assert property (p_rvalid_low) else $error("read valid without read");
  a_hdr_single: assert property (p_hdr_single) else $error("single header type wrong");
  a_memhit: assert property (p_memhit) else $error("memory hit while not enabled");
  a_class: assert property (p_class) else $error("class code wrong");
  a_misc: assert property (p_misc) else $error("self-test or cache byte wrong");
  a_hdr: assert property (p_hdr) else $error("header type wrong");
  a_io: assert property (p_io) else $error("io base low bits wrong");
  a_mem: assert property (p_mem) else $error("mem base low bits wrong");
  a_rom: assert property (p_rom) else $error("rom base low bits wrong");
  a_cap: assert property (p_cap) else $error("capability pointer wrong");
  a_romhit: assert property (p_romhit) else $error("rom hit without memory phase");
  a_end: assert property (p_end) else $error("end while granted");
  c_mem: cover property (MEM_HIT);
  c_rom: cover property (ROM_HIT);
  c_end: cover property (MST_MUST_END);
endmodule : pch_cfg_regs_properties
bind pch_cfg_regs pch_cfg_regs_properties i_pch_cfg_regs_properties (.CLOCK, .SYS_RST,
  .CFG_RD, .CFG_OFS, .CFG_WR, .CFG_WDATA, .CFG_BE,
  .CFG_RDATA, .CFG_RVALID, .MULTI_FUNC_STRAP, .ADDR_VALID,
  .ADDR_IS_MEM, .MEM_HIT, .ROM_HIT, .GNT_ACTIVE, .MST_MUST_END);

/* File: sim/testbench.sv */
`timescale 1ns/1ps
// Testbench: configuration header registers
module testbench
  import pch_pkg::*;
;
  logic clk = 0, rst = 1, rd = 0, wr = 0, strap = 0, ee = 0, av = 0, aio = 0, amem = 0;
  logic fs = 0, fe = 0, rv, ioh, memh, romh, me, lx, gnt;
  logic [7:0] ofs = 0, hold = 0;
  logic [31:0] wd = 0, ad = 0, rdata, s = 32'hb21e8f37;
  logic [3:0] be = 4'hf;
  logic [15:0] w0 = 0, w1 = 0;
  logic [31:0] eq[$], mq[$];
  int failures = 0, n_checks = 0, cyc = 0;
  pch_cfg_regs #(.REV_MAJOR(4'h3), .REV_MINOR(4'h5)) i_pch_cfg_regs (
    .CLOCK(clk), .SYS_RST(rst), .CFG_RD(rd), .CFG_WR(wr), .CFG_OFS(ofs), .CFG_WDATA(wd),
    .CFG_BE(be), .CFG_RDATA(rdata), .CFG_RVALID(rv), .MULTI_FUNC_STRAP(strap), .EE_LOAD(ee),
    .EE_WORD0(w0), .EE_WORD1(w1), .ADDR_VALID(av), .ADDR_IS_IO(aio), .ADDR_IS_MEM(amem),
    .AD(ad), .IO_HIT(ioh), .MEM_HIT(memh), .ROM_HIT(romh), .MST_FRAME_START(fs),
    .MST_FRAME_END(fe), .GNT_ACTIVE(gnt), .MST_MUST_END(me), .LAT_EXPIRED(lx));
  pch_host_model i_pch_host_model (.clk(clk), .rst(rst), .frame_start(fs), .hold(hold),
    .gnt(gnt));
  always #4 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] o, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    rd = !w; wr = w; ofs = o; wd = d;
    if (!w) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    @(negedge clk); rd = 0; wr = 0;
    @(negedge clk);
  endtask : acc
  task automatic wr_rd(input logic [7:0] o, input logic [31:0] e);
    acc(1, o, s, 0, 0);
    acc(0, o, 0, e, 32'hffffffff);
  endtask : wr_rd
  task automatic dec(input logic io, input logic [31:0] a, input logic [2:0] e);
    av = 1; aio = io; amem = !io; ad = a;
    #1 chk("hits", {29'h0, e}, {29'h0, ioh, memh, romh});
    @(negedge clk);
  endtask : dec
  task automatic lat(input logic [7:0] l, h, input int t1, t2, input logic [1:0] e1);
    acc(1, OFS_MISC, {16'h0, l, 8'h0}, 0, 0);
    hold = h; fs = 1;
    @(negedge clk); fs = 0;
    repeat (t1) @(negedge clk);
    chk("end_expired", {30'h0, e1}, {30'h0, me, lx});
    repeat (t2) @(negedge clk);
    chk("end_expired", 32'h3, {30'h0, me, lx});
    fe = 1;
    @(negedge clk); fe = 0;
  endtask : lat
  task automatic conclude();
    if (eq.size() != 0) begin
      failures++;
      $display("Error read queue expected 0 seen %0d", eq.size());
    end
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rv === 1'b1) begin
      if (eq.size() == 0) begin
        failures++;
        $display("Error rvalid expected 0 seen 1");
      end else begin
        chk("rdata", eq.pop_front(), rdata & mq.pop_front());
      end
    end
    if (cyc == 5000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    @(negedge clk);
    acc(0, OFS_CLASS_REV, 0, {CLASS_CODE, 8'h35}, 32'hffffffff);
    acc(0, OFS_MISC, 0, 0, 32'hffffffff);
    acc(0, OFS_IO_BASE, 0, 1, 32'hffffffff);
    acc(0, OFS_CAP_PTR, 0, 32'h50, 32'hffffffff);
    acc(0, 8'h40, 0, 0, 32'hffffffff);
    $display("test reset values done");
    s = lfsr(s);
    wr_rd(OFS_CLASS_REV, {CLASS_CODE, 8'h35});
    wr_rd(OFS_MISC, {16'h0, s[15:8], 8'h00});
    wr_rd(OFS_IO_BASE, {s[31:7], 7'h01});
    wr_rd(OFS_MEM_BASE, {s[31:7], 7'h00});
    wr_rd(OFS_SUBSYS, 0);
    wr_rd(OFS_ROM_BASE, {s[31:18], 17'h0, s[0]});
    wr_rd(OFS_CAP_PTR, 32'h50);
    $display("test write masks done");
    strap = 1;
    repeat (2) @(negedge clk);
    acc(0, OFS_MISC, 0, {8'h0, HDR_MULTI, 16'h0}, 32'h00ff0000);
    strap = 0; w0 = s[15:0]; w1 = s[31:16] ^ 16'h5a5a; ee = 1;
    @(negedge clk); ee = 0;
    acc(0, OFS_SUBSYS, 0, {w1, w0}, 32'hffffffff);
    $display("test strap and eeprom done");
    acc(1, OFS_ROM_BASE, s | 32'h1, 0, 0);
    dec(1, {s[31:7], 7'h12}, 3'b100);
    dec(1, {s[31:8], ~s[7], 7'h12}, 3'b000);
    dec(0, {s[31:7], 7'h05}, 3'b011);
    dec(0, {s[31:8], ~s[7], 7'h00}, 3'b001);
    acc(1, OFS_COMMAND, 32'h1, 0, 0);
    dec(0, {s[31:7], 7'h00}, 3'b000);
    dec(1, {s[31:7], 7'h00}, 3'b100);
    acc(1, OFS_COMMAND, 32'h7, 0, 0);
    acc(1, OFS_ROM_BASE, s & 32'hfffffffe, 0, 0);
    dec(0, {s[31:8], ~s[7], 7'h00}, 3'b000);
    av = 0;
    $display("test decode done");
    be = 4'h4;
    acc(1, OFS_IO_BASE, ~s, 0, 0);
    be = 4'hf;
    acc(0, OFS_IO_BASE, 0, {s[31:24], ~s[23:16], s[15:7], 7'h01}, 32'hffffffff);
    $display("test byte enables done");
    lat(8'h03, 8'h0a, 6, 8, 2'b01);
    lat(8'h08, 8'h01, 3, 8, 2'b00);
    $display("test latency done");
    repeat (4) @(negedge clk);
    conclude();
  end
endmodule : testbench
